/* File: common/twm_pkg.sv */
// Purpose: shared constants and types of the two-wire master
// Assumes: 32-bit AHB-Lite data, 20 MHz system clock
// Notes: offsets are byte addresses inside the 4 KB block window
package twm_pkg;
   localparam int          DW            = 32;
   localparam int          AW            = 12;
   localparam logic [11:0] OFS_TASK_RX   = 12'h000;
   localparam logic [11:0] OFS_TASK_TX   = 12'h008;
   localparam logic [11:0] OFS_TASK_STOP = 12'h014;
   localparam logic [11:0] OFS_INT_STAT  = 12'h300;
   localparam logic [11:0] OFS_INT_MASK  = 12'h304;
   localparam logic [11:0] OFS_ERR_SRC   = 12'h4C4;
   localparam logic [11:0] OFS_ENABLE    = 12'h500;
   localparam logic [11:0] OFS_RATE      = 12'h524;
   localparam logic [11:0] OFS_RX_PTR    = 12'h534;
   localparam logic [11:0] OFS_RX_LIM    = 12'h538;
   localparam logic [11:0] OFS_RX_MOVED  = 12'h53C;
   localparam logic [11:0] OFS_RX_LIST   = 12'h540;
   localparam logic [11:0] OFS_TX_PTR    = 12'h544;
   localparam logic [11:0] OFS_TX_LIM    = 12'h548;
   localparam logic [11:0] OFS_TX_MOVED  = 12'h54C;
   localparam logic [11:0] OFS_TX_LIST   = 12'h550;
   localparam logic [11:0] OFS_TARGET    = 12'h588;
   localparam logic [31:0] RATE_100K     = 32'h01980000;
   localparam logic [31:0] RATE_250K     = 32'h04000000;
   localparam logic [31:0] RATE_RESET    = 32'h04000000;
   localparam int          EN_W          = 4;
   localparam logic [3:0]  ENABLE_ON     = 4'h6;
   localparam int          LIST_W        = 2;
   localparam logic [1:0]  LIST_ARRAY    = 2'h1;
   localparam int          LIM_W         = 13;
   localparam int          TADDR_W       = 7;
   localparam int          EV_W          = 4;
   localparam int          EV_STOPPED    = 0;
   localparam int          EV_ERROR      = 1;
   localparam int          EV_RXSTARTED  = 2;
   localparam int          EV_TXSTARTED  = 3;
   localparam int          ERR_W         = 3;
   localparam int          ERR_ADDR      = 1;
   localparam int          ERR_BYTE      = 2;
   localparam int          SYS_CLK_KHZ   = 20000;
   localparam int          START_LAT_NS  = 1615;
   localparam int          START_LAT_CYC =
      (START_LAT_NS * SYS_CLK_KHZ + 999999) / 1000000;
   localparam int          KBPS_100      = 100;
   localparam int          KBPS_250      = 250;
   localparam logic [7:0]  QTR_100K      = 8'(SYS_CLK_KHZ / (4 * KBPS_100));
   localparam logic [7:0]  QTR_250K      = 8'(SYS_CLK_KHZ / (4 * KBPS_250));
   typedef enum logic [2:0] {
      CMD_START = 3'b001,
      CMD_BYTE  = 3'b010,
      CMD_STOP  = 3'b100
   } twm_cmd_t;
endpackage : twm_pkg

/* File: common/twm_bit_if.sv */
// Purpose: command path between the sequencer and the bit engine
// Assumes: one command outstanding at a time
// Notes: cmd_valid and done are one-cycle pulses
`timescale 1ns/1ps
interface twm_bit_if;
   import twm_pkg::*;
   logic       tick;
   logic       cmd_valid;
   twm_cmd_t   cmd;
   logic       is_read;
   logic       ack_out;
   logic [7:0] tx_byte;
   logic [7:0] rx_byte;
   logic       ack_in;
   logic       done;
   modport ctrl (output tick, cmd_valid, cmd, is_read, ack_out, tx_byte,
                 input  rx_byte, ack_in, done);
   modport eng  (input  tick, cmd_valid, cmd, is_read, ack_out, tx_byte,
                 output rx_byte, ack_in, done);
endinterface : twm_bit_if

/* File: rtl/twm_bit_engine.sv */
// Purpose: start, byte and stop sequencing on the open-drain pins
// Assumes: tick is a quarter-bit enable from the sequencer
// Notes: waits while the slave holds the clock low
`timescale 1ns/1ps
module twm_bit_engine (
   input  wire logic sys_clk,
   input  wire logic reset,
   twm_bit_if.eng    bus,
   input  wire logic scl_in,
   output logic      scl_out,
   output logic      scl_oe_n,
   input  wire logic sda_in,
   output logic      sda_out,
   output logic      sda_oe_n
);
   import twm_pkg::*;
   typedef enum logic [3:0] {
      E_IDLE  = 4'b0001,
      E_START = 4'b0010,
      E_BYTE  = 4'b0100,
      E_STOP  = 4'b1000
   } twm_eng_t;
   twm_eng_t   state;
   logic [2:0] scl_s;
   logic [2:0] sda_s;
   logic       scl_f;
   logic       sda_f;
   logic [1:0] phase;
   logic [3:0] bitn;
   logic [8:0] shreg;
   logic [8:0] rx;
   logic       scl_low;
   logic       sda_low;
   logic       step;

   // pads only ever pull low
   assign scl_out  = 1'b0;
   assign sda_out  = 1'b0;
   assign scl_oe_n = ~scl_low;
   assign sda_oe_n = ~sda_low;
   assign bus.rx_byte = rx[8:1];
   assign bus.ack_in  = rx[0];

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         scl_s <= 3'h7;
         sda_s <= 3'h7;
         scl_f <= 1'b1;
         sda_f <= 1'b1;
      end else begin
         scl_s <= {scl_s[1:0], scl_in};
         sda_s <= {sda_s[1:0], sda_in};
         if (scl_s[1] == scl_s[2]) begin
            scl_f <= scl_s[2];
         end
         if (sda_s[1] == sda_s[2]) begin
            sda_f <= sda_s[2];
         end
      end
   end

   // stretching: phase 2 holds until the clock line is seen high
   assign step = bus.tick & ~((phase == 2'h2) & ~scl_f);

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         state   <= E_IDLE;
         phase   <= 2'h0;
         bitn    <= 4'h0;
         shreg   <= 9'h1FF;
         rx      <= 9'h1FF;
         scl_low <= 1'b0;
         sda_low <= 1'b0;
         bus.done <= 1'b0;
      end else begin
         bus.done <= 1'b0;
         case (state)
            E_IDLE: begin
               phase <= 2'h0;
               bitn  <= 4'h0;
               if (bus.cmd_valid) begin
                  case (bus.cmd)
                     CMD_START: state <= E_START;
                     CMD_BYTE:  state <= E_BYTE;
                     CMD_STOP:  state <= E_STOP;
                     default:   state <= E_IDLE;
                  endcase
                  shreg <= bus.is_read ? {8'hFF, bus.ack_out}
                                       : {bus.tx_byte, 1'b1};
               end
            end
            E_START: if (step) begin
               phase <= phase + 2'h1;
               case (phase)
                  2'h0: sda_low <= 1'b1; // RQ8
                  2'h3: begin
                     scl_low  <= 1'b1;
                     bus.done <= 1'b1;
                     state    <= E_IDLE;
                  end
                  default: ;
               endcase
            end
            E_BYTE: if (step) begin
               phase <= phase + 2'h1;
               case (phase)
                  2'h0: sda_low <= ~shreg[8];
                  2'h1: scl_low <= 1'b0;
                  2'h2: rx <= {rx[7:0], sda_f};
                  default: begin
                     scl_low <= 1'b1;
                     shreg   <= {shreg[7:0], 1'b1};
                     bitn    <= bitn + 4'h1;
                     if (bitn == 4'h8) begin
                        bus.done <= 1'b1;
                        state    <= E_IDLE;
                     end
                  end
               endcase
            end
            E_STOP: if (step) begin
               phase <= phase + 2'h1;
               case (phase)
                  2'h0: sda_low <= 1'b1;
                  2'h1: scl_low <= 1'b0;
                  2'h3: begin
                     sda_low  <= 1'b0;
                     bus.done <= 1'b1;
                     state    <= E_IDLE;
                  end
                  default: ;
               endcase
            end
            default: state <= E_IDLE;
         endcase
      end
   end
endmodule : twm_bit_engine

/* File: rtl/twm_top.sv */
// Purpose: two-wire bus master with byte DMA and AHB-Lite registers
// Assumes: one 20 MHz clock, open-drain pads and pull-ups outside
// Notes: writes take no wait state, reads take one
// Summary of operation
// [RQ1] rate code 0x01980000 gives 100 kbps, 0x04000000 gives 250 kbps
// [RQ2] each direction keeps a 32-bit RAM start address for its bytes
// [RQ3] receive limit of 13 bits caps bytes written to RAM
// [RQ4] transmit limit of 13 bits caps bytes fetched from RAM
// [RQ5] moved counts readable after a transfer, refused byte included
// [RQ6] list kind per direction: 0 off, 1 consecutive array buffers
// [RQ7] 7-bit target address sent right after the start condition
// [RQ8] bus activity begins about 1.615 us after a start task; here SDA falls one quarter bit (50 or 20 cycles) after the 33-cycle wait
// [RQ9] sticky refused flags for address and data, write one clears
// [RQ10] master runs only while enable field holds 6; enable is only checked when a transfer starts
// [RQ11] byte moves stop once count reaches the limit
//
// Chosen here: register access over AHB-Lite.
`timescale 1ns/1ps
module twm_top (
   input  wire logic                    sys_clk,
   input  wire logic                    reset,
   input  wire logic                    hsel,
   input  wire logic [31:0]             haddr,
   input  wire logic [1:0]              htrans,
   input  wire logic                    hwrite,
   input  wire logic [2:0]              hsize,
   input  wire logic [twm_pkg::DW-1:0]  hwdata,
   input  wire logic                    hready,
   output logic      [twm_pkg::DW-1:0]  hrdata,
   output logic                         hreadyout,
   output logic                         hresp,
   output logic                         dma_req,
   output logic                         dma_we,
   output logic      [31:0]             dma_addr,
   output logic      [7:0]              dma_wdata,
   input  wire logic [7:0]              dma_rdata,
   input  wire logic                    dma_ready,
   input  wire logic                    scl_in,
   output logic                         scl_out,
   output logic                         scl_oe_n,
   input  wire logic                    sda_in,
   output logic                         sda_out,
   output logic                         sda_oe_n,
   output logic                         irq
);
   import twm_pkg::*;
   typedef enum logic [8:0] {
      M_IDLE  = 9'b000000001,
      M_LAT   = 9'b000000010,
      M_START = 9'b000000100,
      M_ADDR  = 9'b000001000,
      M_FETCH = 9'b000010000,
      M_WRITE = 9'b000100000,
      M_READ  = 9'b001000000,
      M_STORE = 9'b010000000,
      M_STOP  = 9'b100000000
   } twm_state_t;
   twm_bit_if bi ();
   twm_state_t          state;
   logic [31:0]         rx_buffer_pointer;
   logic [LIM_W-1:0]    rx_byte_limit;
   logic [LIM_W-1:0]    rx_bytes_moved;
   logic [LIST_W-1:0]   rx_list_kind;
   logic [31:0]         tx_buffer_pointer;
   logic [LIM_W-1:0]    tx_byte_limit;
   logic [LIM_W-1:0]    tx_bytes_moved;
   logic [LIST_W-1:0]   tx_list_kind;
   logic [TADDR_W-1:0]  target_address;
   logic [31:0]         bit_rate_select;
   logic [EN_W-1:0]     enable_field;
   logic [EV_W-1:0]     int_stat;
   logic [EV_W-1:0]     int_mask;
   logic [EV_W-1:0]     ev_set;
   logic [ERR_W-1:0]    err_src;
   logic [ERR_W-1:0]    err_set;
   logic                ap_wr;
   logic                rd_wait;
   logic [AW-1:0]       ap_addr;
   logic                accept;
   logic [31:0]         rd_val;
   logic                go_rx, go_tx, go_stop;
   logic                enabled, dir_rx, stop_req, ptr_adv;
   logic [31:0]         base;
   logic [LIM_W-1:0]    lim_q;
   logic [LIM_W-1:0]    cnt;
   logic [LIM_W-1:0]    cnt_inc;
   logic [7:0]          lat;
   logic [7:0]          qcnt;
   logic [7:0]          qlim;
   function automatic logic [7:0] rate_qtr(input logic [31:0] code);
      rate_qtr = (code == RATE_100K) ? QTR_100K : QTR_250K; // RQ1
   endfunction : rate_qtr
   twm_bit_engine u_eng (
      .sys_clk  (sys_clk),
      .reset    (reset),
      .bus      (bi.eng),
      .scl_in   (scl_in),
      .scl_out  (scl_out),
      .scl_oe_n (scl_oe_n),
      .sda_in   (sda_in),
      .sda_out  (sda_out),
      .sda_oe_n (sda_oe_n)
   );

   assign accept    = hsel & htrans[1] & hready;
   assign hreadyout = ~rd_wait;
   assign hresp     = 1'b0;
   assign enabled   = (enable_field == ENABLE_ON); // RQ10
   assign cnt_inc   = cnt + 13'h1;
   assign qlim      = rate_qtr(bit_rate_select);

   // one wait state on reads so a preceding write is always visible
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         ap_wr   <= 1'b0;
         rd_wait <= 1'b0;
         ap_addr <= 12'h000;
      end else begin
         ap_wr   <= accept & hwrite;
         rd_wait <= accept & ~hwrite;
         if (accept) begin
            ap_addr <= haddr[AW-1:0];
         end
      end
   end

   always_comb begin
      case (ap_addr)
         OFS_INT_STAT: rd_val = 32'(int_stat);
         OFS_INT_MASK: rd_val = 32'(int_mask);
         OFS_ERR_SRC:  rd_val = 32'(err_src);
         OFS_ENABLE:   rd_val = 32'(enable_field);
         OFS_RATE:     rd_val = bit_rate_select;
         OFS_RX_PTR:   rd_val = rx_buffer_pointer;
         OFS_RX_LIM:   rd_val = 32'(rx_byte_limit);
         OFS_RX_MOVED: rd_val = 32'(rx_bytes_moved); // RQ5
         OFS_RX_LIST:  rd_val = 32'(rx_list_kind);
         OFS_TX_PTR:   rd_val = tx_buffer_pointer;
         OFS_TX_LIM:   rd_val = 32'(tx_byte_limit);
         OFS_TX_MOVED: rd_val = 32'(tx_bytes_moved); // RQ5
         OFS_TX_LIST:  rd_val = 32'(tx_list_kind);
         OFS_TARGET:   rd_val = 32'(target_address);
         default:      rd_val = 32'h00000000;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         hrdata <= 32'h00000000;
      end else if (rd_wait) begin
         hrdata <= rd_val;
      end
   end
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         rx_buffer_pointer <= 32'h00000000;
         rx_byte_limit     <= 13'h0000;
         rx_list_kind      <= 2'h0;
         tx_buffer_pointer <= 32'h00000000;
         tx_byte_limit     <= 13'h0000;
         tx_list_kind      <= 2'h0;
         target_address    <= 7'h00;
         bit_rate_select   <= RATE_RESET;
         enable_field      <= 4'h0;
         int_mask          <= 4'h0;
         go_rx             <= 1'b0;
         go_tx             <= 1'b0;
         go_stop           <= 1'b0;
      end else begin
         go_rx   <= ap_wr & (ap_addr == OFS_TASK_RX) & hwdata[0];
         go_tx   <= ap_wr & (ap_addr == OFS_TASK_TX) & hwdata[0];
         go_stop <= ap_wr & (ap_addr == OFS_TASK_STOP) & hwdata[0];
         if (ptr_adv && dir_rx) begin
            rx_buffer_pointer <= rx_buffer_pointer + 32'(lim_q); // RQ6
         end
         if (ptr_adv && !dir_rx) begin
            tx_buffer_pointer <= tx_buffer_pointer + 32'(lim_q); // RQ6
         end
         if (ap_wr) begin
            case (ap_addr)
               OFS_RX_PTR:   rx_buffer_pointer <= hwdata; // RQ2
               OFS_RX_LIM:   rx_byte_limit <= hwdata[LIM_W-1:0]; // RQ3
               OFS_RX_LIST:  rx_list_kind <= hwdata[LIST_W-1:0];
               OFS_TX_PTR:   tx_buffer_pointer <= hwdata; // RQ2
               OFS_TX_LIM:   tx_byte_limit <= hwdata[LIM_W-1:0]; // RQ4
               OFS_TX_LIST:  tx_list_kind <= hwdata[LIST_W-1:0];
               OFS_TARGET:   target_address <= hwdata[TADDR_W-1:0];
               OFS_RATE:     bit_rate_select <= hwdata;
               OFS_ENABLE:   enable_field <= hwdata[EN_W-1:0];
               OFS_INT_MASK: int_mask <= hwdata[EV_W-1:0];
               default: ;
            endcase
         end
      end
   end
   // sticky status: a new event beats the read that clears it
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         int_stat <= 4'h0;
         irq      <= 1'b0;
      end else begin
         if (rd_wait && ap_addr == OFS_INT_STAT) begin
            int_stat <= ev_set;
         end else begin
            int_stat <= int_stat | ev_set;
         end
         irq <= |(int_stat & int_mask);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         err_src <= 3'h0;
      end else if (ap_wr && ap_addr == OFS_ERR_SRC) begin
         err_src <= (err_src & ~hwdata[ERR_W-1:0]) | err_set; // RQ9
      end else begin
         err_src <= err_src | err_set; // RQ9
      end
   end
   // quarter-bit enable; held in reset while idle so a frame starts clean
   always_ff @(posedge sys_clk) begin
      if (reset || state == M_IDLE || state == M_LAT) begin
         qcnt    <= 8'h00;
         bi.tick <= 1'b0;
      end else if (qcnt == qlim - 8'h01) begin
         qcnt    <= 8'h00;
         bi.tick <= 1'b1; // RQ1
      end else begin
         qcnt    <= qcnt + 8'h01;
         bi.tick <= 1'b0;
      end
   end
   task automatic issue(input twm_cmd_t c, input logic rd, input logic ak,
                        input logic [7:0] b);
      bi.cmd_valid <= 1'b1;
      bi.cmd       <= c;
      bi.is_read   <= rd;
      bi.ack_out   <= ak;
      bi.tx_byte   <= b;
   endtask : issue

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         state          <= M_IDLE;
         bi.cmd_valid   <= 1'b0;
         bi.cmd         <= CMD_STOP;
         bi.is_read     <= 1'b0;
         bi.ack_out     <= 1'b1;
         bi.tx_byte     <= 8'hFF;
         ev_set         <= 4'h0;
         err_set        <= 3'h0;
         ptr_adv        <= 1'b0;
         dir_rx         <= 1'b0;
         stop_req       <= 1'b0;
         base           <= 32'h00000000;
         lim_q          <= 13'h0000;
         cnt            <= 13'h0000;
         lat            <= 8'h00;
         rx_bytes_moved <= 13'h0000;
         tx_bytes_moved <= 13'h0000;
         dma_req        <= 1'b0;
         dma_we         <= 1'b0;
         dma_addr       <= 32'h00000000;
         dma_wdata      <= 8'h00;
      end else begin
         bi.cmd_valid <= 1'b0;
         ev_set       <= 4'h0;
         err_set      <= 3'h0;
         ptr_adv      <= 1'b0;
         case (state)
            M_IDLE: if (enabled && (go_rx || go_tx)) begin // RQ10
               dir_rx   <= go_rx;
               base     <= go_rx ? rx_buffer_pointer : tx_buffer_pointer;
               lim_q    <= go_rx ? rx_byte_limit : tx_byte_limit;
               cnt      <= 13'h0000;
               lat      <= 8'h00;
               stop_req <= 1'b0;
               if (go_rx) begin
                  rx_bytes_moved <= 13'h0000;
                  ev_set[EV_RXSTARTED] <= 1'b1;
               end else begin
                  tx_bytes_moved <= 13'h0000;
                  ev_set[EV_TXSTARTED] <= 1'b1;
               end
               state <= M_LAT;
            end
            M_LAT: begin
               lat <= lat + 8'h01;
               if (lat == 8'(START_LAT_CYC - 1)) begin // RQ8
                  issue(CMD_START, 1'b0, 1'b1, 8'hFF);
                  state <= M_START;
               end
            end
            M_START: if (bi.done) begin
               issue(CMD_BYTE, 1'b0, 1'b1, {target_address, dir_rx}); // RQ7
               state <= M_ADDR;
            end
            M_ADDR: if (bi.done) begin
               err_set[ERR_ADDR] <= bi.ack_in; // RQ9
               ev_set[EV_ERROR]  <= bi.ack_in;
               if (bi.ack_in || lim_q == 13'h0000 || stop_req) begin
                  issue(CMD_STOP, 1'b0, 1'b1, 8'hFF);
                  state <= M_STOP;
               end else if (dir_rx) begin
                  // refuse the last byte so the slave frees the data line
                  issue(CMD_BYTE, 1'b1, cnt_inc == lim_q, 8'hFF);
                  state <= M_READ;
               end else begin
                  dma_req  <= 1'b1;
                  dma_we   <= 1'b0;
                  dma_addr <= base + 32'(cnt); // RQ2
                  state    <= M_FETCH;
               end
            end
            M_FETCH: if (dma_ready) begin
               dma_req <= 1'b0;
               issue(CMD_BYTE, 1'b0, 1'b1, dma_rdata);
               state   <= M_WRITE;
            end
            M_WRITE: if (bi.done) begin
               cnt            <= cnt_inc;
               tx_bytes_moved <= cnt_inc; // RQ5
               err_set[ERR_BYTE] <= bi.ack_in; // RQ9
               ev_set[EV_ERROR]  <= bi.ack_in;
               if (bi.ack_in || cnt_inc >= lim_q || stop_req) begin // RQ11
                  issue(CMD_STOP, 1'b0, 1'b1, 8'hFF);
                  state <= M_STOP;
               end else begin
                  dma_req  <= 1'b1;
                  dma_addr <= base + 32'(cnt_inc); // RQ4
                  state    <= M_FETCH;
               end
            end
            M_READ: if (bi.done) begin
               dma_req   <= 1'b1;
               dma_we    <= 1'b1;
               dma_addr  <= base + 32'(cnt); // RQ2
               dma_wdata <= bi.rx_byte;
               state     <= M_STORE;
            end
            M_STORE: if (dma_ready) begin
               dma_req        <= 1'b0;
               dma_we         <= 1'b0;
               cnt            <= cnt_inc;
               rx_bytes_moved <= cnt_inc; // RQ5
               if (cnt_inc >= lim_q || stop_req) begin // RQ3 RQ11
                  issue(CMD_STOP, 1'b0, 1'b1, 8'hFF);
                  state <= M_STOP;
               end else begin
                  issue(CMD_BYTE, 1'b1, cnt_inc + 13'h1 == lim_q, 8'hFF);
                  state <= M_READ;
               end
            end
            M_STOP: if (bi.done) begin
               ev_set[EV_STOPPED] <= 1'b1;
               ptr_adv <= ((dir_rx ? rx_list_kind : tx_list_kind)
                           == LIST_ARRAY); // RQ6
               state   <= M_IDLE;
            end
            default: state <= M_IDLE;
         endcase
         if (go_stop && state != M_IDLE) begin
            stop_req <= 1'b1;
         end
      end
   end
endmodule : twm_top

/* File: tb/twm_chk.sv */
// Purpose: port checks of twm_top
// Assumes: sync reset, active high
// Notes: bound in the bench
`timescale 1ns/1ps
module twm_chk (
   input wire logic        sys_clk, reset, hsel, hready, hwrite,
   input wire logic [1:0]  htrans,
   input wire logic        hreadyout, hresp, dma_req, dma_ready, dma_we,
   input wire logic [31:0] dma_addr,
   input wire logic        scl_out, sda_out, scl_oe_n, sda_oe_n, irq
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (reset);
   wire go = hsel && htrans[1] && hready;
   property p_ok; !hresp; endproperty
   a_ok: assert property (p_ok) else $error("hresp");
   property p_rd; go && !hwrite |=> !hreadyout ##1 hreadyout; endproperty
   a_rd: assert property (p_rd) else $error("read wait");
   property p_wr; go && hwrite |=> hreadyout; endproperty
   a_wr: assert property (p_wr) else $error("write wait");
   property p_one; !hreadyout |=> hreadyout; endproperty
   a_one: assert property (p_one) else $error("wait length");
   property p_hold; dma_req && !dma_ready |=> dma_req && $stable(dma_addr);
   endproperty
   a_hold: assert property (p_hold) else $error("ram hold");
   property p_drop; dma_req && dma_ready |=> !dma_req; endproperty
   a_drop: assert property (p_drop) else $error("ram drop");
   property p_od; !scl_out && !sda_out; endproperty
   a_od: assert property (p_od) else $error("pin level");
   property p_rst; $past(reset) |-> !irq && !dma_req && scl_oe_n && sda_oe_n;
   endproperty
   a_rst: assert property (p_rst) else $error("reset state");
endmodule : twm_chk

/* File: tb/twm_slave.sv */
// Purpose: target on the two-wire bus
// Assumes: no clock stretching here
// Notes: written bytes queued in got
`timescale 1ns/1ps
module twm_slave (
   input wire logic       scl, sda,
   input wire logic [6:0] my_addr,
   input wire logic [7:0] rd_byte,
   output logic           sda_rel
);
   logic [7:0] sh;
   logic       act = 0, adr, rd, hit;
   int         n;
   logic [7:0] got[$];
   initial sda_rel = 1;
   always @(negedge sda) if (scl) begin act = 1; adr = 1; n = 0; end
   always @(posedge sda) if (scl) act = 0;
   always @(posedge scl) if (act) begin
      if (n < 8) sh = {sh[6:0], sda};
      if (n == 7 && adr) begin rd = sda; hit = sh[7:1] == my_addr; end
      if (n == 8 && !adr && !rd) got.push_back(sh);
      if (n == 8 && !adr && rd && sda) hit = 0; // master refused, let go
      if (n == 8) adr = 0;
      n = n == 8 ? 0 : n + 1;
   end
   always @(negedge scl) begin
      sda_rel <= 1;
      if (act && n == 8 && (adr ? hit : !rd)) sda_rel <= 0;
      if (act && !adr && rd && hit && n < 8) sda_rel <= rd_byte[7 - n];
   end
endmodule : twm_slave

/* File: tb/twm_top_bench.sv */
// Purpose: self-checking bench of twm_top
// Assumes: RAM model answers after random delay
// Notes: pull-ups modelled by wired and
`timescale 1ns/1ps
module twm_top_bench;
   import twm_pkg::*;
   logic sys_clk = 0, reset, hwrite, hreadyout, hresp, irq, sl_rel;
   logic dma_req, dma_we, dma_ready, scl_out, scl_oe_n, sda_out, sda_oe_n;
   logic [1:0]  htrans;
   logic [31:0] haddr, hwdata, hrdata, dma_addr, v;
   logic [7:0]  dma_wdata, dma_rdata, rd_byte, mem[int];
   logic [6:0]  sl_addr;
   int          error_cnt = 0, n_compared = 0, c, p;
   logic [11:0] ra[7] = '{OFS_RX_PTR, OFS_RX_LIM, OFS_RX_MOVED,
      OFS_TX_LIST, OFS_TX_MOVED, OFS_TARGET, 12'hFF0};
   logic [31:0] rm[7] = '{'1, 32'h1FFF, 0, 32'h3, 0, 32'h7F, 0};
   wire scl = scl_oe_n;
   wire sda = sda_oe_n & sl_rel;
   always #25 sys_clk = ~sys_clk;
   twm_top dut (.*, .hsel(1'b1), .hready(hreadyout), .hsize(3'h2),
      .scl_in(scl), .sda_in(sda));
   twm_slave sl (.scl, .sda, .my_addr(sl_addr), .rd_byte, .sda_rel(sl_rel));
   always @(posedge sys_clk) begin // slow or prompt RAM
      dma_ready <= dma_req && !dma_ready && 1'($urandom_range(1));
      dma_rdata <= dma_req ? mem[dma_addr] : ~dma_rdata;
      if (dma_req && dma_ready && dma_we) mem[dma_addr] = dma_wdata;
   end
   task close_out();
      $display("compared %0d errors %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : close_out
   task chk(input string s, input logic [31:0] e, g);
      n_compared++;
      if (g !== e) begin
         error_cnt++;
         $display("unexpected %s exp %h got %h", s, e, g);
      end
   endtask : chk
   task rdy();
      for (c = 0; c < 9; c++) begin
         @(posedge sys_clk);
         if (hreadyout) break;
      end
      if (c == 9) begin chk("hready", 1, 0); close_out(); end
   endtask : rdy
   task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      htrans <= 2'h2; hwrite <= w; haddr <= {20'h0, a};
      rdy();
      htrans <= 2'h0; hwdata <= d;
      rdy();
      v = hrdata;
   endtask : bus
   task rc(input logic [11:0] a, input logic [31:0] e);
      bus(0, a, 0);
      chk($sformatf("reg %h", a), e, v);
   endtask : rc
   task lvl(input logic l);
      for (c = 0; c < 900 && scl !== l; c++) @(posedge sys_clk);
      p += c;
   endtask : lvl
   task go(input logic [11:0] t, input int per);
      bus(1, t, 1);
      for (c = 0; c < 300 && sda_oe_n; c++) @(posedge sys_clk);
      chk("start delay", 1, c inside {[33:95]});
      lvl(0); lvl(1); p = 0; lvl(0); lvl(1);
      chk("bit cycles", 1, p inside {[per:per+8]});
      for (c = 0; c < 20000 && irq !== 1; c++) @(posedge sys_clk);
      if (irq !== 1) begin chk("irq", 1, irq); close_out(); end
   endtask : go
   initial begin
      void'($urandom(32'hC309));
      reset = 1; htrans = 0; hwrite = 0; haddr = 0; hwdata = 0;
      dma_ready = 0; dma_rdata = 0; sl_addr = $urandom; rd_byte = $urandom;
      repeat (2) @(posedge sys_clk);
      reset <= 0;
      @(posedge sys_clk);
      rc(OFS_RATE, RATE_250K);
      foreach (ra[i]) begin
         rc(ra[i], 0);
         bus(1, ra[i], '1);
         rc(ra[i], rm[i]);
      end
      for (int i = 0; i < 4; i++) begin
         mem[256 + i] = $urandom;
         mem[512 + i] = 8'h5A;
      end
      bus(1, OFS_RATE, RATE_100K); bus(1, OFS_ENABLE, 6);
      bus(1, OFS_TARGET, sl_addr); bus(1, OFS_TX_LIST, 0);
      bus(1, OFS_TX_PTR, 256); bus(1, OFS_TX_LIM, 2); bus(1, OFS_INT_MASK, 1);
      go(OFS_TASK_TX, 200);
      rc(OFS_INT_STAT, 9);
      rc(OFS_TX_MOVED, 2);
      chk("tx count", 2, sl.got.size());
      foreach (sl.got[i]) chk("tx byte", mem[256 + i], sl.got[i]);
      bus(1, OFS_RATE, RATE_250K); bus(1, OFS_RX_PTR, 512);
      bus(1, OFS_RX_LIM, 3); bus(1, OFS_RX_LIST, 1);
      go(OFS_TASK_RX, 80);
      rc(OFS_INT_STAT, 5);
      for (int i = 0; i < 4; i++)
         chk("rx ram", i < 3 ? rd_byte : 8'h5A, mem[512 + i]);
      rc(OFS_RX_MOVED, 3);
      rc(OFS_RX_PTR, 515);
      bus(1, OFS_TARGET, sl_addr ^ 7'h1);
      go(OFS_TASK_TX, 80);
      rc(OFS_ERR_SRC, 2);
      bus(1, OFS_INT_MASK, 0); bus(1, OFS_ERR_SRC, 2);
      rc(OFS_ERR_SRC, 0);
      chk("irq masked", 0, irq);
      bus(1, OFS_INT_MASK, 1);
      rc(OFS_INT_MASK, 1);
      chk("irq raised", 1, irq);
      rc(OFS_INT_STAT, 32'hB);
      rc(OFS_INT_STAT, 0);
      chk("irq cleared", 0, irq);
      close_out();
   end
endmodule : twm_top_bench
bind twm_top twm_chk chk_i (.*);
